// ### hw/host_port_strap_config.sv
// strap-configured host port: decode, interrupt, dma, parity, fill start
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module host_port_strap_config
  import strap_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // strap pins, static during operation
  input  wire strap_t      strap_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output      logic [31:0] reg_rdata_o,
  // host register access decode
  input  wire logic [17:0] host_addr_i,
  input  wire logic        host_strobe_i,
  output      logic        host_sel_o,
  output      logic [4:0]  host_index_o,
  // interrupt
  output      logic        irq_o,
  output      logic [3:0]  bus_req_level_o,
  output      logic [8:0]  vector_o,
  // dma sequencing
  input  wire logic        xfer_pend_i,
  input  wire logic        dma_grant_i,
  input  wire logic        mem_done_i,
  input  wire logic        block_end_i,
  input  wire logic        late_i,
  output      logic        dma_bus_request_o,
  output      logic        bus_held_o,
  output      logic        mem_cycle_o,
  output      logic        port_b_o,
  // dma read data
  input  wire logic        dma_read_cycle_i,
  input  wire dma_word_t   rd_word_i,
  output      logic [17:0] rd_data_o,
  // write start
  input  wire logic [6:0]  fifo_count_i,
  output      logic        write_go_o
);

  // whole module state
  typedef struct packed {
    dma_st_t         fsm;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [1:0]      ctrl;
    logic [31:0]     rdata;
    logic            pend_d;
    logic            hit;
    logic [4:0]      index;
    logic [17:0]     rd_data;
    logic            go;
  } st_t;

  localparam st_t ST_INIT = '{
    fsm:     DMA_IDLE,
    status:  '0,
    mask:    MASK_RESET,
    ctrl:    CTRL_RESET,
    rdata:   '0,
    pend_d:  1'b0,
    hit:     1'b0,
    index:   '0,
    rd_data: '0,
    go:      1'b0
  };

  st_t    st;        // registered state
  st_t    next_st;   // next state
  strap_t s;         // synchronised straps

  // fill threshold, read by write start and config readback
  function automatic logic [6:0] thr_of(input strap_t x);
    if (x.fill64)
      thr_of = THR_64;
    else if (x.fill32)
      thr_of = THR_32;
    else if (x.fill16)
      thr_of = THR_16;
    else
      thr_of = THR_1;
  endfunction

  // straps come from pins, so they cross two flops first
  pin_sync #(.W($bits(strap_t))) u_sync
  (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .pin_i     (strap_i),
    .sync_o    (s)
  );

  // derived configuration
  logic [4:0]  reg_cnt;    // decoded register count
  logic [12:0] diff;       // word offset into block
  logic        addr_hit;   // host address in window
  logic        port_b_eff; // port actually used
  logic        hog;        // block burst mode active
  logic        par_chk;    // parity checked on used port
  logic        par_err;    // parity fault on read word
  logic        pend_ok;    // request may be raised
  logic [ST_W-1:0] ev;     // events this cycle
  logic        done_rd;    // completed read reference

  // removed strap adds its weight, max 30
  assign reg_cnt = {~s.regcnt, 1'b0};

  // installed strap compares against 0
  assign diff = {1'b0, host_addr_i[12:1]}
              - {1'b0, ~s.addr, 4'h0};
  assign addr_hit = (host_addr_i[17:13] == IO_PAGE)
                 && !diff[12]
                 && (diff[11:0] < {7'h00, reg_cnt});

  // hardware override of software port choice
  assign port_b_eff = st.ctrl[CT_PORT_B] && !s.port_a_only;
  assign hog = !s.one_cycle && !s.block_burst && port_b_eff;

  // each port has its own parity strap
  assign par_chk = port_b_eff ? s.par_b : s.par_a;
  assign done_rd = mem_done_i && dma_read_cycle_i
                && (st.fsm == DMA_XFER);
  // odd parity per byte, low line guards low byte
  assign par_err = par_chk &&
    (!(^{rd_word_i.data[7:0], rd_word_i.par[0]}) ||
     !(^{rd_word_i.data[15:8], rd_word_i.par[1]}));

  // without the latency strap the pending level must settle a cycle
  assign pend_ok = xfer_pend_i && (s.latency || st.pend_d);

  // events feeding the sticky status
  always_comb
  begin
    ev            = '0;
    ev[ST_MISSED] = late_i && s.missed_xfer;
    ev[ST_PAR_A]  = done_rd && par_err && !port_b_eff;
    ev[ST_PAR_B]  = done_rd && par_err && port_b_eff;
    ev[ST_BLOCK]  = mem_done_i && block_end_i
                 && (st.fsm == DMA_XFER);
  end

  // next state
  always_comb
  begin
    next_st        = st;
    next_st.pend_d = xfer_pend_i;
    next_st.rdata  = '0;
    next_st.hit    = 1'b0;
    next_st.go     = fifo_count_i >= thr_of(s);

    // host register decode, answered one cycle later
    if (host_strobe_i)
    begin
      next_st.hit   = addr_hit;
      next_st.index = diff[4:0];
    end

    // read data word, unchecked parity lines become bits 16 and 17, checked ones read as zero
    if (done_rd)
      next_st.rd_data = par_chk ? {2'b00, rd_word_i.data}
                                : rd_word_i;

    // sticky status, a set beats the read clear
    if (reg_rd_i && reg_addr_i == OFS_STATUS)
      next_st.status = ev;
    else
      next_st.status = st.status | ev;

    // software writes
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_MASK:
          next_st.mask = reg_wdata_i[ST_W-1:0];
        OFS_CTRL:
          next_st.ctrl = reg_wdata_i[1:0];
        default:
          next_st.mask = st.mask; // unmapped or read only
      endcase
    end

    // reads, unmapped addresses answer zero
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        OFS_STATUS:
          next_st.rdata[ST_W-1:0] = st.status;
        OFS_MASK:
          next_st.rdata[ST_W-1:0] = st.mask;
        OFS_CTRL:
          next_st.rdata[1:0] = st.ctrl;
        OFS_CONFIG:
        begin
          next_st.rdata[CF_THR +: 7] = thr_of(s);
          next_st.rdata[CF_CNT +: 5] = reg_cnt;
          next_st.rdata[CF_VEC +: 9] = {s.vec, 2'b00};
          next_st.rdata[CF_LVL +: 2] = s.level;
          next_st.rdata[CF_PRT]      = port_b_eff;
        end
        default:
          next_st.rdata = '0;
      endcase
    end

    // dma sequencer
    case (st.fsm)
      DMA_IDLE:
        // wait for a word and software enable
        if (st.ctrl[CT_DMA_EN] && pend_ok)
          next_st.fsm = DMA_REQ;
      DMA_REQ:
        // hold request until granted
        if (dma_grant_i)
          next_st.fsm = DMA_XFER;
      DMA_XFER:
      begin
        if (mem_done_i)
        begin
          // one reference per grant, else run on
          if (s.one_cycle)
            next_st.fsm = DMA_IDLE;
          else if (block_end_i)
            next_st.fsm = DMA_IDLE;
          else if (!hog && !xfer_pend_i)
            next_st.fsm = DMA_IDLE;
        end
        else if (!hog && !xfer_pend_i)
          next_st.fsm = DMA_IDLE;
      end
      default:
        next_st.fsm = DMA_IDLE;
    endcase

    // dropping enable abandons a pending request, a transfer in progress runs on
    if (!st.ctrl[CT_DMA_EN] && st.fsm != DMA_XFER)
      next_st.fsm = DMA_IDLE;
  end

  // state register, synchronous active low reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      st <= ST_INIT;
    else
      st <= next_st;
  end

  // outputs
  assign reg_rdata_o  = st.rdata;
  assign host_sel_o   = st.hit;
  assign host_index_o = st.index;
  assign irq_o        = |(st.status & st.mask);
  // plugged level selects one request line
  assign bus_req_level_o = irq_o ? (4'h1 << s.level)
                                 : 4'h0;
  assign vector_o = {s.vec, 2'b00};
  assign dma_bus_request_o = (st.fsm == DMA_REQ);
  assign bus_held_o  = (st.fsm == DMA_XFER);
  assign mem_cycle_o = bus_held_o && xfer_pend_i;
  assign port_b_o    = port_b_eff;
  assign rd_data_o   = st.rd_data;
  assign write_go_o  = st.go;

  // checks

  a_decode_hit: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    host_strobe_i |=> host_sel_o == $past(addr_hit))
    else $error("host decode mismatch");

  a_count_limit: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    host_sel_o |-> host_index_o < reg_cnt)
    else $error("index beyond register count");

  a_level_line: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    irq_o |-> bus_req_level_o[s.level] && $onehot(bus_req_level_o))
    else $error("request on wrong level");

  a_vector_bits: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    vector_o[1:0] == 2'b00 && vector_o[8:2] == s.vec)
    else $error("vector bits wrong");

  a_latency_delay: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (!s.latency && st.fsm == DMA_IDLE && !st.pend_d)
      |=> !dma_bus_request_o)
    else $error("early request without strap");

  a_missed_gate: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (late_i && s.missed_xfer) |=> st.status[ST_MISSED])
    else $error("missed transfer not flagged");

  a_missed_off: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (!s.missed_xfer && !st.status[ST_MISSED])
      |=> !st.status[ST_MISSED])
    else $error("missed transfer flagged while off");

  a_one_ref: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (s.one_cycle && bus_held_o && mem_done_i) |=> !bus_held_o)
    else $error("second reference in one grant");

  a_hog_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (hog && bus_held_o && !block_end_i && st.ctrl[CT_DMA_EN])
      |=> bus_held_o)
    else $error("bus released inside block");

  a_par_data: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (done_rd && !par_chk) |=> rd_data_o == $past(rd_word_i))
    else $error("parity lines not passed as data");

  a_write_go: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (s.fill64 && fifo_count_i < THR_64) |=> !write_go_o)
    else $error("write start below threshold");

  a_port_a_only: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    s.port_a_only |-> !port_b_o)
    else $error("port b used despite override");

endmodule

// ### common/strap_cfg_pkg.sv
// constants, strap layout and register map of the host port configuration
// Operation
// - address straps set host bits twelve to five
// - standard setting answers block 776700 to 776746
// - register count strap group limits decoded registers
// - interrupt request at plugged priority level
// - vector bits two to eight from straps
// - latency strap enables early dma requests
// - missed transfer detection only while strap installed
// - one cycle strap gives one reference per grant
// - both straps cut holds port b bus
// - port a parity checked or lines carry data
// - port b parity strap works independently
// - disk write waits for strap fill threshold
// - port a only strap overrides port b
package strap_cfg_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK   = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  localparam logic [3:0] OFS_CONFIG = 4'hc;

  // status and mask bit positions
  localparam int ST_MISSED = 0;
  localparam int ST_PAR_A  = 1;
  localparam int ST_PAR_B  = 2;
  localparam int ST_BLOCK  = 3;
  localparam int ST_W      = 4;

  // control bit positions and reset values
  localparam int CT_PORT_B = 0;
  localparam int CT_DMA_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // config readback field positions
  localparam int CF_THR = 0;
  localparam int CF_CNT = 8;
  localparam int CF_VEC = 16;
  localparam int CF_LVL = 28;
  localparam int CF_PRT = 30;

  // host page select, bits 17 to 13 all ones
  localparam logic [4:0] IO_PAGE = 5'h1f;

  // write start fill thresholds in words
  localparam logic [6:0] THR_64 = 7'h40;
  localparam logic [6:0] THR_32 = 7'h20;
  localparam logic [6:0] THR_16 = 7'h10;
  localparam logic [6:0] THR_1  = 7'h01;

  // strap set, a 1 bit means the strap is installed
  typedef struct packed {
    logic [7:0] addr;        // host address bits 12..5
    logic [3:0] regcnt;      // weights 16,8,4,2
    logic [1:0] level;       // plug code, 1 = level five
    logic [6:0] vec;         // vector bits 8..2
    logic       latency;     // latency_strap
    logic       missed_xfer; // missed_xfer_strap
    logic       one_cycle;   // dma_cycle_strap_group one cycle
    logic       block_burst; // dma_cycle_strap_group burst pair
    logic       par_a;
    logic       par_b;
    logic       fill64;
    logic       fill32;
    logic       fill16;
    logic       port_a_only;
  } strap_t;

  // dma read word with its two parity lines on top
  typedef struct packed {
    logic [1:0]  par;        // parity_line_high, parity_line_low
    logic [15:0] data;
  } dma_word_t;

  // dma sequencer states
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_REQ  = 3'b010,
    DMA_XFER = 3'b100
  } dma_st_t;

endpackage

// ### hw/pin_sync.sv
// two flip-flop synchroniser for static strap pins
`timescale 1ns/1ps
module pin_sync
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  // pins and synchronised copy
  input  wire logic [W-1:0] pin_i,
  output      logic [W-1:0] sync_o
);

  // first stage is read only by the second
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t st;       // registered state
  sync_st_t next_st;  // next state

  // shift the pins through two stages
  always_comb
  begin
    next_st.meta   = pin_i;
    next_st.stable = st.meta;
  end

  // synchronous reset to all removed
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_o = st.stable;

endmodule

// ### tb/host_mem_model.sv
// host side model: grants dma, paces references, answers read words
`timescale 1ns/1ps
module host_mem_model
  import strap_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // device side of the port
  input  wire logic       req_i,
  input  wire logic       held_i,
  input  wire logic       cyc_i,
  // bench controls
  input  wire logic       slow_i,
  input  wire logic       bad_par_i,
  // host answers
  output      logic       grant_o,
  output      logic       done_o,
  output      dma_word_t  word_o,
  output      logic [7:0] most_o
);
  logic [2:0]  wait_q; // grant delay count
  logic [2:0]  pace_q; // reference pacing
  logic [7:0]  cur_q;  // references in this grant
  logic [15:0] n_q;    // read word counter
  logic [15:0] d;      // next read word

  assign d = n_q + 16'h5a3c;

  // grant after a short or long wait; pace memory references
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      grant_o <= 1'b0;
      done_o  <= 1'b0;
      wait_q  <= 3'h0;
      pace_q  <= 3'h0;
      cur_q   <= 8'h00;
      most_o  <= 8'h00;
      n_q     <= 16'h0000;
      word_o  <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      // lines flip every cycle outside a reference, so the stale word returns every second cycle
      word_o <= ~word_o;
      if (req_i && !grant_o)
      begin
        wait_q  <= wait_q + 3'h1;
        grant_o <= (wait_q >= (slow_i ? 3'h4 : 3'h0));
      end
      else if (!req_i && !held_i)
      begin
        // device let go, the grant is over
        grant_o <= 1'b0;
        wait_q  <= 3'h0;
        cur_q   <= 8'h00;
      end
      if (cyc_i && !done_o)
      begin
        pace_q <= pace_q + 3'h1;
        if (pace_q >= (slow_i ? 3'h3 : 3'h1))
        begin
          // one reference ends, odd parity per byte unless spoiled
          done_o <= 1'b1;
          pace_q <= 3'h0;
          n_q    <= n_q + 16'h0001;
          cur_q  <= cur_q + 8'h01;
          if (cur_q >= most_o)
            most_o <= cur_q + 8'h01;
          word_o <= {~^d[15:8], (~^d[7:0]) ^ bad_par_i, d};
        end
      end
      else
        pace_q <= 3'h0;
    end
  end
endmodule

// ### tb/tb.sv
// self-checking bench for the strap-configured host port
`timescale 1ns/1ps
module tb
  import strap_cfg_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  strap_t      straps = '0;
  strap_t      std;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [17:0] host_addr = 18'h0_0000;
  logic        host_strobe = 1'b0;
  logic        host_sel;
  logic [4:0]  host_index;
  logic        irq;
  logic [3:0]  req_level;
  logic [8:0]  vector;
  logic        pend = 1'b0;
  logic        blk = 1'b0;
  logic        late = 1'b0;
  logic        slow = 1'b0;
  logic        bad_par = 1'b0;
  logic        grant;
  logic        done;
  logic        dma_req;
  logic        held;
  logic        mem_cyc;
  logic        port_b;
  dma_word_t   word;
  dma_word_t   lw;
  logic [17:0] rd_data;
  logic [6:0]  fifo = 7'h00;
  logic        go;
  logic [7:0]  most;
  int          fails = 0;
  int          comparisons = 0;

  // 200 MHz
  always #2.5 clk = ~clk;

  // last word the host handed over
  always @(posedge clk)
    if (done === 1'b1)
      lw <= word;

  host_port_strap_config i_dut (
    .clk_sys_i(clk), .resetn_i(resetn), .strap_i(straps),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .host_addr_i(host_addr), .host_strobe_i(host_strobe),
    .host_sel_o(host_sel), .host_index_o(host_index),
    .irq_o(irq), .bus_req_level_o(req_level), .vector_o(vector),
    .xfer_pend_i(pend), .dma_grant_i(grant), .mem_done_i(done),
    .block_end_i(blk), .late_i(late), .dma_bus_request_o(dma_req),
    .bus_held_o(held), .mem_cycle_o(mem_cyc), .port_b_o(port_b),
    .dma_read_cycle_i(done), .rd_word_i(word), .rd_data_o(rd_data),
    .fifo_count_i(fifo), .write_go_o(go));

  host_mem_model i_host (
    .clk_sys_i(clk), .resetn_i(resetn), .req_i(dma_req), .held_i(held),
    .cyc_i(mem_cyc), .slow_i(slow), .bad_par_i(bad_par),
    .grant_o(grant), .done_o(done), .word_o(word), .most_o(most));

  task automatic close_out();
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // straps only change while reset is held
  task automatic setup(input strap_t s, input int n);
    @(posedge clk);
    resetn <= 1'b0;
    straps <= s;
    repeat (n) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("register read", exp, reg_rdata);
  endtask

  task automatic hq(input logic [17:0] a, input logic hit,
                    input logic [4:0] ix);
    @(posedge clk);
    host_addr <= a;
    host_strobe <= 1'b1;
    @(posedge clk);
    host_strobe <= 1'b0;
    #1 chk("host select", hit, host_sel);
    if (hit)
      chk("host index", ix, host_index);
  endtask

  task automatic pulse_late();
    @(posedge clk);
    late <= 1'b1;
    @(posedge clk);
    late <= 1'b0;
  endtask

  // cycles from pending word to bus request
  task automatic lat(input int exp);
    int n;
    n = 0;
    @(posedge clk);
    pend <= 1'b1;
    while (dma_req !== 1'b1 && n < 9)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("request delay", exp, n);
  endtask

  task automatic burst(input int n);
    @(posedge clk);
    pend <= 1'b1;
    repeat (n) @(posedge clk);
    pend <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end

  initial
  begin
    strap_t     s;
    logic [6:0] thr [4];
    thr = '{THR_64, THR_32, THR_16, THR_1};
    // base 776700, 20 regs, level five, vector 254, subsystem dma straps
    std = {8'h11, 4'h5, 2'h1, 7'h2b, 10'h378};
    setup(std, 20);
    rd(OFS_STATUS, 32'h0000_0000);
    rd(OFS_MASK, 32'h0000_0000);
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_CONFIG, 32'h10ac_1440);
    rd(4'h6, 32'h0000_0000);
    chk("vector", 9'h0ac, vector);
    for (int k = 0; k < 20; k++)
      hq(18'h3_fdc0 + 18'(2 * k), 1'b1, 5'(k));
    hq(18'h3_fde8, 1'b0, 5'h00);
    hq(18'h3_fdbe, 1'b0, 5'h00);
    // missed transfer event, masked then unmasked
    pulse_late();
    #1 chk("irq masked", 1'b0, irq);
    wr(OFS_STATUS, 32'h0000_000f);
    wr(OFS_MASK, 32'h0000_0001);
    #1 chk("irq", 1'b1, irq);
    chk("request level", 4'h2, req_level);
    rd(OFS_STATUS, 32'h0000_0001);
    #1 chk("irq cleared", 1'b0, irq);
    rd(OFS_STATUS, 32'h0000_0000);
    // slow host, back-to-back references allowed
    slow <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0002);
    lat(1);
    repeat (60) @(posedge clk);
    pend <= 1'b0;
    slow <= 1'b0;
    repeat (20) @(posedge clk);
    chk("refs per grant", 1'b1, most > 8'h01);
    chk("bus released", 1'b0, held);
    chk("parity data", {16'h0000, lw.data}, rd_data);
    rd(OFS_STATUS, 32'h0000_0000);
    // one reference per grant, slow request, 18-bit port a
    s = std;
    {s.one_cycle, s.latency, s.par_a, s.missed_xfer} = 4'h8;
    setup(s, 4);
    bad_par <= 1'b1;
    pulse_late();
    wr(OFS_CTRL, 32'h0000_0002);
    lat(2);
    burst(60);
    chk("refs per grant", 8'h01, most);
    chk("wide data", lw, rd_data);
    rd(OFS_STATUS, 32'h0000_0000);
    // port a checks parity, port b carries data
    s = std;
    s.par_b = 1'b0;
    setup(s, 4);
    wr(OFS_CTRL, 32'h0000_0002);
    burst(30);
    rd(OFS_STATUS, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0003);
    burst(30);
    chk("port b data", lw, rd_data);
    rd(OFS_STATUS, 32'h0000_0000);
    // block burst mode keeps the bus until a block end
    bad_par <= 1'b0;
    s = std;
    s.block_burst = 1'b0;
    setup(s, 4);
    wr(OFS_CTRL, 32'h0000_0003);
    burst(30);
    chk("bus kept", 1'b1, held);
    @(posedge clk);
    blk <= 1'b1;
    pend <= 1'b1;
    for (int n = 0; n < 40 && done !== 1'b1; n++)
      @(posedge clk) #1;
    @(posedge clk);
    pend <= 1'b0;
    blk <= 1'b0;
    repeat (5) @(posedge clk);
    chk("bus freed", 1'b0, held);
    rd(OFS_STATUS, 32'h0000_0008);
    // port a only, base moved to bits 12..5 all zero
    s.port_a_only = 1'b1;
    s.addr = 8'hff;
    setup(s, 4);
    wr(OFS_CTRL, 32'h0000_0003);
    #1 chk("port b", 1'b0, port_b);
    burst(30);
    chk("bus freed", 1'b0, held);
    hq(18'h3_e000, 1'b1, 5'h00);
    hq(18'h3_ffc0, 1'b0, 5'h00);
    // fill thresholds, each strap alone and none
    for (int k = 0; k < 4; k++)
    begin
      s = std;
      {s.fill64, s.fill32, s.fill16} = 3'h4 >> k;
      setup(s, 4);
      fifo <= thr[k] - 7'h01;
      repeat (3) @(posedge clk);
      #1 chk("write start", 1'b0, go);
      @(posedge clk);
      fifo <= thr[k];
      repeat (3) @(posedge clk);
      #1 chk("write start", 1'b1, go);
    end
    close_out();
  end
endmodule
